/* File: core/fspc_pkg.sv */
package fspc_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_CSR     = 5'h00; // Control and status
  localparam logic [4:0] ADDR_PTR     = 5'h04; // Flash address pointer
  localparam logic [4:0] ADDR_DATA    = 5'h08; // Word data pair
  localparam logic [4:0] ADDR_CMD     = 5'h0C; // Store / load instruction strobes
  localparam logic [4:0] ADDR_LDRES   = 5'h10; // Result of the last load
  localparam int         ADDR_W       = 5;

  // Control register fields
  localparam int         CSR_W        = 8;
  localparam int         CMD_BITS_W   = 5;     // Low command bits that decode
  localparam int         STORE_ENABLE_BIT_POS    = 0;
  localparam int         PAGE_ERASE_BIT_POS    = 1;
  localparam int         PAGE_WRITE_BIT_POS    = 2;
  localparam int         FUSE_LOCK_READ_SELECT_POS     = 3;
  localparam int         CLEAR_PAGE_BUFFER_BIT_POS     = 4;
  localparam logic [2:0] CSR_RSVD_VAL = 3'h0;  // Bits 7..5 read as zero

  // Accepted command patterns in the low five bits
  localparam logic [4:0] PAT_CLEAR_PAGE_BUFFER_BIT     = 5'h11; // 10001
  localparam logic [4:0] PAT_FUSE_LOCK_READ_SELECT     = 5'h09; // 01001
  localparam logic [4:0] PAT_PAGE_WRITE_BIT    = 5'h05; // 00101
  localparam logic [4:0] PAT_PAGE_ERASE_BIT    = 5'h03; // 00011
  localparam logic [4:0] PAT_STORE    = 5'h01; // 00001

  // Instruction strobe bits in the command register
  localparam int         CMD_STORE_POS = 0;
  localparam int         CMD_LOAD_POS  = 1;

  // Fuse and lock selection by pointer value
  localparam logic [1:0] SEL_FUSE_LO  = 2'h0;
  localparam logic [1:0] SEL_LOCK     = 2'h1;
  localparam logic [1:0] SEL_FUSE_HI  = 2'h3;
  localparam logic [7:0] BYTE_UNPROG  = 8'hFF; // Unused selection reads unprogrammed

  // Instruction windows in clock cycles
  localparam logic [2:0] STORE_WIN    = 3'h4;
  localparam logic [2:0] LOAD_WIN     = 3'h3;

  // Flash operation timing
  localparam int         CLK_HZ       = 10_000_000;
  localparam int         PROG_MIN_NS  = 3_700_000; // 3.7 ms
  localparam int         PROG_MAX_NS  = 4_500_000; // 4.5 ms
  localparam int         CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int         PROG_MIN_CYC = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int         PROG_MAX_CYC = PROG_MAX_NS / CLK_NS;

  // Page buffer geometry
  localparam int         PTR_W        = 16;
  localparam int         WORD_W       = 16;
  localparam logic [15:0] WORD_ERASED = 16'hFFFF;

  // Flash operation states
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_WRITE
  } fspc_op_t;
endpackage

/* File: core/fspc_ctrl.sv */
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int OP_CYCLES  = PROG_MIN_CYC, // Flash operation length in cycles
  parameter int PAGE_WORDS = 16            // Words per flash page
) (
  input  wire logic              clk_sys_in,         // System clock, 10 MHz
  input  wire logic              rst_n_in,           // System reset, async, active low
  input  wire logic              por_n_in,           // Supply-good reset, async, active low
  input  wire logic [ADDR_W-1:0] avs_address_in,     // Avalon byte address
  input  wire logic              avs_read_in,        // Avalon read
  input  wire logic              avs_write_in,       // Avalon write
  input  wire logic [31:0]       avs_writedata_in,   // Avalon write data
  output logic [31:0]            avs_readdata_out,   // Avalon read data
  output logic                   avs_waitrequest_out,// Avalon wait request
  input  wire logic [7:0]        flash_rdata_in,     // Flash byte at pointer
  input  wire logic [7:0]        fuse_lo_prog_in,    // Fuse low, 1 = programmed
  input  wire logic [7:0]        fuse_hi_prog_in,    // Fuse high, 1 = programmed
  input  wire logic [7:0]        lock_prog_in,       // Lock bits, 1 = programmed
  input  wire logic              eeprom_busy_in,     // EEPROM write in progress
  output logic [PTR_W-1:0]       flash_addr_out,     // Byte address for flash reads
  output logic [PTR_W-1:0]       flash_page_out,     // Pointer latched for erase/write
  output logic                   flash_erase_out,    // Page erase running
  output logic                   flash_write_out,    // Page write running
  output logic                   flash_word_we_out,  // Buffer word strobe to flash
  output logic [WORD_W-1:0]      flash_word_out,     // Buffer word to flash
  output logic                   cpu_halt_out        // CPU halted during erase/write
);

  localparam int IDX_W = $clog2(PAGE_WORDS);
  localparam int CNT_W = $clog2(OP_CYCLES + 1);
  localparam logic [CNT_W-1:0] OP_LOAD = CNT_W'(OP_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [IDX_W:0]   STREAM_END = (IDX_W + 1)'(PAGE_WORDS);

  // Bus handshake and decode
  logic              ack_r;          // High in the cycle waitrequest is low
  logic              ack_nxt;
  logic              wait_r;         // Registered waitrequest, high until an answer
  logic [31:0]       rdata_r;        // Read data register
  logic [31:0]       rdata_nxt;
  logic              op_busy;        // Erase or write running
  logic              wr_acc;         // Write taken this edge
  logic              csr_wr;
  logic              cmd_wr;

  // Software-visible state
  logic [PTR_W-1:0]  ptr_r;          // Address pointer
  logic [WORD_W-1:0] data_r;         // Word data pair
  logic [7:0]        ldres_r;        // Last load result
  logic [3:0]        ctl_r;          // Command bits 3..0, sticky until cleared
  logic [3:0]        ctl_nxt;
  logic [2:0]        win_r;          // Cycles left in the instruction window
  logic [2:0]        win_nxt;
  logic [7:0]        csr_val;        // Control register readback

  // Command decode
  logic [4:0]        wpat;
  logic              pat_ok;
  logic              store_acc;
  logic              load_acc;
  logic              store_open;
  logic              load_open;
  logic              fuse_rd;
  logic              erase_go;
  logic              write_go;
  logic              buf_store;
  logic              buf_clear;
  logic              expire;
  logic [7:0]        fuse_byte;
  logic [7:0]        load_val;
  logic [IDX_W-1:0]  word_idx;

  // Flash operation sequencer
  fspc_op_t          op_state_r;
  fspc_op_t          op_nxt;
  logic [CNT_W-1:0]  op_cnt_r;
  logic              op_done;
  logic [IDX_W:0]    stream_r;       // Words sent to flash so far
  logic              stream_on;

  // Temporary page buffer, one word per entry
  logic [WORD_W-1:0] page_buf_r [PAGE_WORDS];

  // Fuse and lock byte by pointer, inverted so programmed reads zero
  function automatic logic [7:0] fuse_pick(input logic [1:0] sel, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic [7:0] lk);
    logic [7:0] prog;
    prog = 8'h00;
    case (sel)
      SEL_FUSE_LO: prog = lo;
      SEL_LOCK:    prog = lk;
      SEL_FUSE_HI: prog = hi;
      default:     prog = ~BYTE_UNPROG;
    endcase
    return ~prog;
  endfunction

  // The CPU is halted during flash operations, so every access stalls then
  assign op_busy   = (op_state_r != OP_IDLE);
  assign ack_nxt   = (avs_read_in | avs_write_in) & ~ack_r & ~op_busy;
  assign wr_acc    = ack_r & avs_write_in;
  assign csr_wr    = wr_acc & (avs_address_in == ADDR_CSR);
  assign cmd_wr    = wr_acc & (avs_address_in == ADDR_CMD);
  assign store_acc = cmd_wr & avs_writedata_in[CMD_STORE_POS];
  assign load_acc  = cmd_wr & avs_writedata_in[CMD_LOAD_POS];

  // Command pattern decode; EEPROM activity blocks every pattern
  assign wpat   = avs_writedata_in[CMD_BITS_W-1:0];
  assign pat_ok = ~eeprom_busy_in & ((wpat == PAT_CLEAR_PAGE_BUFFER_BIT) | (wpat == PAT_FUSE_LOCK_READ_SELECT) |
                  (wpat == PAT_PAGE_WRITE_BIT) | (wpat == PAT_PAGE_ERASE_BIT) | (wpat == PAT_STORE));

  // Windows counted from the control write
  assign store_open = ctl_r[STORE_ENABLE_BIT_POS] & (win_r != 3'h0);
  assign load_open  = ctl_r[FUSE_LOCK_READ_SELECT_POS] & (win_r > (STORE_WIN - LOAD_WIN));
  assign fuse_rd    = load_acc & load_open & ~eeprom_busy_in;
  assign erase_go   = store_acc & store_open & ctl_r[PAGE_ERASE_BIT_POS];
  assign write_go   = store_acc & store_open & ctl_r[PAGE_WRITE_BIT_POS];
  assign buf_store  = store_acc & store_open & (ctl_r == PAT_STORE[3:0]);
  assign buf_clear  = csr_wr & pat_ok & (wpat == PAT_CLEAR_PAGE_BUFFER_BIT);

  // Fuse-read lapses after the load window, other commands after the store window
  assign expire = (win_r == 3'h1) |
                  (ctl_r[FUSE_LOCK_READ_SELECT_POS] & (win_r == (STORE_WIN - LOAD_WIN + 3'h1)));

  assign fuse_byte = fuse_pick(ptr_r[1:0], fuse_lo_prog_in, fuse_hi_prog_in,
                               lock_prog_in);
  assign load_val  = fuse_rd ? fuse_byte : flash_rdata_in;
  assign word_idx  = ptr_r[IDX_W:1]; // Pointer bit zero ignored for buffer words

  // Command bits: a new pattern, a completed instruction, a timeout or op end
  assign ctl_nxt =
    (csr_wr & pat_ok)                  ? wpat[3:0] :
    (erase_go | write_go)              ? ctl_r :      // held while busy
    (op_busy)                          ? (op_done ? 4'h0 : ctl_r) :
    (store_acc & store_open)           ? 4'h0 :
    (fuse_rd)                          ? 4'h0 :
    (expire & ~store_acc)              ? 4'h0 :
                                         ctl_r;
  assign win_nxt =
    (csr_wr & pat_ok)                  ? STORE_WIN :
    (store_acc & store_open) | fuse_rd ? 3'h0 :
    (expire)                           ? 3'h0 :
    (win_r != 3'h0)                    ? win_r - 3'h1 :
                                         3'h0;

  // Reserved bits read zero; store-enable reads high while busy
  assign csr_val = {CSR_RSVD_VAL, 1'b0, ctl_r[FUSE_LOCK_READ_SELECT_POS], ctl_r[PAGE_WRITE_BIT_POS],
                    ctl_r[PAGE_ERASE_BIT_POS], ctl_r[STORE_ENABLE_BIT_POS] | op_busy};

  // Read mux; unmapped addresses read zero
  assign rdata_nxt =
    (avs_address_in == ADDR_CSR)   ? {24'h0, csr_val} :
    (avs_address_in == ADDR_PTR)   ? {16'h0, ptr_r} :
    (avs_address_in == ADDR_DATA)  ? {16'h0, data_r} :
    (avs_address_in == ADDR_LDRES) ? {24'h0, ldres_r} :
                                     32'h0;

  // Sequencer next state; only a store inside the window starts it
  assign op_done   = op_busy & (op_cnt_r == CNT_ONE);
  assign op_nxt    = op_done  ? OP_IDLE :
                     erase_go ? OP_ERASE :
                     write_go ? OP_WRITE :
                                op_state_r;
  assign stream_on = (op_state_r == OP_WRITE) & (stream_r < STREAM_END);

  // Bus handshake: an access takes two edges when no operation is running
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r   <= 1'b0;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      ack_r   <= ack_nxt;
      wait_r  <= ~ack_nxt;
      rdata_r <= ack_nxt ? rdata_nxt : rdata_r;
    end
  end

  // Pointer, data pair and load result written by the CPU side
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_r   <= 16'h0000;
      data_r  <= 16'h0000;
      ldres_r <= 8'h00;
    end else begin
      if (wr_acc && avs_address_in == ADDR_PTR) ptr_r <= avs_writedata_in[PTR_W-1:0];
      if (wr_acc && avs_address_in == ADDR_DATA) data_r <= avs_writedata_in[WORD_W-1:0];
      if (load_acc) ldres_r <= load_val;
    end
  end

  // Command bits and window counter; system reset clears them
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r <= 4'h0;
      win_r <= 3'h0;
    end else begin
      ctl_r <= ctl_nxt;
      win_r <= win_nxt;
    end
  end

  // Sequencer sits on the supply-good reset so a system reset lets it finish
  always_ff @(posedge clk_sys_in or negedge por_n_in) begin
    if (!por_n_in) begin
      op_state_r      <= OP_IDLE;
      op_cnt_r        <= '0;
      stream_r        <= '0;
      flash_page_out  <= 16'h0000;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      cpu_halt_out    <= 1'b0;
    end else begin
      op_state_r      <= op_nxt;
      op_cnt_r        <= (erase_go | write_go) ? OP_LOAD :
                         (op_busy ? op_cnt_r - CNT_ONE : op_cnt_r);
      stream_r        <= write_go ? '0 : (stream_on ? stream_r + 1'b1 : stream_r);
      if (erase_go | write_go) flash_page_out <= ptr_r;
      flash_erase_out <= (op_nxt == OP_ERASE);
      flash_write_out <= (op_nxt == OP_WRITE);
      cpu_halt_out    <= (op_nxt != OP_IDLE);
    end
  end

  // Buffer words go to the flash one per cycle at the start of a page write
  always_ff @(posedge clk_sys_in or negedge por_n_in) begin
    if (!por_n_in) begin
      flash_word_we_out <= 1'b0;
      flash_word_out    <= 16'h0000;
    end else begin
      flash_word_we_out <= stream_on;
      flash_word_out    <= stream_on ? page_buf_r[stream_r[IDX_W-1:0]] : flash_word_out;
    end
  end

  // Page buffer: cleared on power-up, on system reset when idle, after a
  // page write and on the clear-buffer command
  generate
    for (genvar gi = 0; gi < PAGE_WORDS; gi++) begin : g_buf
      always_ff @(posedge clk_sys_in or negedge por_n_in) begin
        if (!por_n_in) begin
          page_buf_r[gi] <= WORD_ERASED;
        end else if ((!rst_n_in && !op_busy) || buf_clear ||
                     (op_done && op_state_r == OP_WRITE)) begin
          page_buf_r[gi] <= WORD_ERASED;
        end else if (buf_store && word_idx == IDX_W'(gi)) begin
          page_buf_r[gi] <= data_r;
        end
      end
    end
  endgenerate

  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out    = rdata_r;
  assign flash_addr_out      = ptr_r;

  // Cycles since the last operation start, checked against the set operation length
  logic [CNT_W:0] op_age_r;
  always_ff @(posedge clk_sys_in or negedge por_n_in) begin
    if (!por_n_in) op_age_r <= '0;
    else           op_age_r <= (erase_go | write_go) ? '0 : op_age_r + 1'b1;
  end

  property p_ctl_timeout;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (csr_wr && pat_ok && wpat == PAT_STORE) ##1 (!store_acc)[*4] |=> (ctl_r == 4'h0);
  endproperty
  a_ctl_timeout: assert property (p_ctl_timeout) else $error("Store-enable did not lapse");

  property p_rsvd_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in) csr_val[7:5] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits not zero");

  property p_bad_pattern;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (csr_wr && !pat_ok && !op_busy && win_r == 3'h0) |=> $stable(ctl_r);
  endproperty
  a_bad_pattern: assert property (p_bad_pattern) else $error("Bad pattern changed bits");

  property p_write_start;
    @(posedge clk_sys_in) disable iff (!rst_n_in || !por_n_in)
    write_go |=> flash_write_out && cpu_halt_out && csr_val[0] ##1 flash_word_we_out;
  endproperty
  a_write_start: assert property (p_write_start) else $error("Page write did not start");

  property p_halt_busy;
    @(posedge clk_sys_in) disable iff (!por_n_in)
    cpu_halt_out |-> avs_waitrequest_out && op_busy;
  endproperty
  a_halt_busy: assert property (p_halt_busy) else $error("Halt does not track busy");

  property p_erase_start;
    @(posedge clk_sys_in) disable iff (!rst_n_in || !por_n_in)
    erase_go |=> flash_erase_out && ctl_r[PAGE_ERASE_BIT_POS] && avs_waitrequest_out;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("Page erase did not start");

  property p_fuse_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (fuse_rd && ptr_r[1:0] == SEL_FUSE_LO) |=>
      ldres_r == ~$past(fuse_lo_prog_in) && ctl_r == 4'h0;
  endproperty
  a_fuse_read: assert property (p_fuse_read) else $error("Fuse read wrong");

  property p_lock_val;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (fuse_rd && ptr_r == 16'h0001) |=> ldres_r == ~$past(lock_prog_in);
  endproperty
  a_lock_val: assert property (p_lock_val) else $error("Lock byte wrong");

  property p_plain_load;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (load_acc && ctl_r == 4'h0) |=> ldres_r == $past(flash_rdata_in);
  endproperty
  a_plain_load: assert property (p_plain_load) else $error("Plain load wrong");

  // Default length sits inside the allowed band; a shortened run still counts exactly
  property p_op_time;
    @(posedge clk_sys_in) disable iff (!por_n_in)
    op_done |-> op_age_r == (CNT_W + 1)'(OP_CYCLES - 1);
  endproperty
  a_op_time: assert property (p_op_time) else $error("Operation length out of range");

  property p_eeprom_block;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (csr_wr && eeprom_busy_in && win_r == 3'h0 && !op_busy) |=> ctl_r == 4'h0;
  endproperty
  a_eeprom_block: assert property (p_eeprom_block) else $error("EEPROM did not block");

  property p_fuse_high;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (fuse_rd && ptr_r[1:0] == SEL_FUSE_HI) |=> ldres_r == ~$past(fuse_hi_prog_in);
  endproperty
  a_fuse_high: assert property (p_fuse_high) else $error("Fuse high byte wrong");

  // Three edges without a load after a fuse-read pattern drop every command bit
  property p_fuse_lapse;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (csr_wr && pat_ok && wpat == PAT_FUSE_LOCK_READ_SELECT) ##1 (!load_acc && !csr_wr)[*3] |=> ctl_r == 4'h0;
  endproperty
  a_fuse_lapse: assert property (p_fuse_lapse) else $error("Fuse-read did not lapse");

  property p_buf_clear;
    @(posedge clk_sys_in) disable iff (!por_n_in)
    buf_clear |=> page_buf_r[word_idx] == WORD_ERASED;
  endproperty
  a_buf_clear: assert property (p_buf_clear) else $error("Page buffer not cleared");

  // Halt and command bits both end with the operation
  property p_op_end;
    @(posedge clk_sys_in) disable iff (!por_n_in)
    op_done |=> !cpu_halt_out && ctl_r == 4'h0;
  endproperty
  a_op_end: assert property (p_op_end) else $error("Operation end left state behind");

endmodule

/* File: dv/fspc_flash_model.sv */
`timescale 1ns/1ps
// Behavioural flash array on the far side of the sequencer
module fspc_flash_model
  import fspc_pkg::*;
(
  input  wire logic              clk_sys_in,  // System clock
  input  wire logic [PTR_W-1:0]  addr_in,     // Byte address for loads
  input  wire logic [PTR_W-1:0]  page_in,     // Pointer latched at operation start
  input  wire logic              erase_in,    // Page erase running
  input  wire logic              write_in,    // Page write running
  input  wire logic              word_we_in,  // One strobe per streamed word
  input  wire logic [WORD_W-1:0] word_in,     // Streamed buffer word
  output logic      [7:0]        rdata_out    // Byte at load address
);
  logic [7:0] mem_r [0:255];  // Small array; upper address bits alias onto it
  logic       erase_d_r;      // Erase level one cycle back
  logic [3:0] idx_r;          // Word index within a page write
  logic [7:0] base;           // First byte of the latched page

  // Page taken from the upper pointer bits, word bits ignored
  assign base = {page_in[7:5], 5'h00};
  // Load path sees the array contents directly
  assign rdata_out = mem_r[addr_in[7:0]];

  // Start from a cleared array so an erase is visible as FF
  initial begin
    erase_d_r = 1'b0;
    for (int i = 0; i < 256; i++) mem_r[i] = 8'h00;
  end

  // Erase on the first cycle of the operation, store words as they stream
  always @(posedge clk_sys_in) begin
    erase_d_r <= erase_in;
    if (erase_in && !erase_d_r) begin
      for (int i = 0; i < 32; i++) mem_r[base + i[7:0]] <= 8'hFF;
    end
    if (!write_in) begin
      idx_r <= 4'h0;
    end else if (word_we_in) begin
      mem_r[base + {3'h0, idx_r, 1'b0}]         <= word_in[7:0];
      mem_r[base + {3'h0, idx_r, 1'b0} + 8'h01] <= word_in[15:8];
      idx_r                                     <= idx_r + 4'h1;
    end
  end
endmodule

/* File: dv/flash_self_program_control_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
// Self-checking bench: the bench acts as the CPU on the register bus
module flash_self_program_control_bench
  import fspc_pkg::*;
;
  localparam int OPC = 20;       // Shortened operation length for simulation
  logic              clk_sys_in, rst_n_in, por_n_in;
  logic [ADDR_W-1:0] avs_address_in;
  logic              avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [31:0]       avs_writedata_in, avs_readdata_out;
  logic [7:0]        flash_rdata_in, fuse_lo, fuse_hi, lock_b;
  logic              eeprom_busy_in, erase_o, write_o, word_we_o, cpu_halt_out;
  logic [15:0]       addr_o, page_o, word_o;
  int                miscompares, checks;

  fspc_ctrl #(.OP_CYCLES(OPC), .PAGE_WORDS(16)) fspc_ctrl_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .flash_rdata_in(flash_rdata_in), .fuse_lo_prog_in(fuse_lo), .fuse_hi_prog_in(fuse_hi),
    .lock_prog_in(lock_b), .eeprom_busy_in(eeprom_busy_in), .flash_addr_out(addr_o),
    .flash_page_out(page_o), .flash_erase_out(erase_o), .flash_write_out(write_o),
    .flash_word_we_out(word_we_o), .flash_word_out(word_o), .cpu_halt_out(cpu_halt_out));

  fspc_flash_model fspc_flash_model_i (
    .clk_sys_in(clk_sys_in), .addr_in(addr_o), .page_in(page_o), .erase_in(erase_o),
    .write_in(write_o), .word_we_in(word_we_o), .word_in(word_o), .rdata_out(flash_rdata_in));

  // 100 ns clock
  always #50 clk_sys_in = ~clk_sys_in;

  // One Avalon access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    // Halted during erase/write; only the watchdog ends a wait that never ends
    do begin
      @(posedge clk_sys_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // Plain store into the page buffer at a pointer
  task automatic store(input logic [15:0] p, input logic [15:0] d);
    wr(ADDR_PTR, {16'h0, p});
    wr(ADDR_DATA, {16'h0, d});
    wr(ADDR_CSR, 32'h01);
    wr(ADDR_CMD, 32'h01);
  endtask

  // Count cycles with the CPU halted until the operation ends
  task automatic wait_op(output int n);
    n = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_sys_in);
      if (cpu_halt_out === 1'b1) n++;
      else if (n != 0) break;
    end
  endtask

  task automatic t_regs;
    logic [31:0] q;
    rd(ADDR_CSR, q); `CHK("csr after reset", 32'h0, q)
    wr(5'h14, 32'hFF);
    rd(5'h14, q); `CHK("unmapped read", 32'h0, q)
    // Reserved bits written high must read back zero
    wr(ADDR_CSR, 32'hE1);
    rd(ADDR_CSR, q); `CHK("csr store enable", 32'h01, q)
    rd(ADDR_CSR, q); `CHK("csr self clear", 32'h0, q)
  endtask

  // Every fuse selection including the unused pointer value
  task automatic t_fuse;
    logic [31:0] q;
    logic [15:0] p[4];
    logic [7:0]  e[4];
    p = '{16'h0000, 16'h0001, 16'h0003, 16'h0002};
    e = '{~fuse_lo, ~lock_b, ~fuse_hi, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PTR, {16'h0, p[i]});
      wr(ADDR_CSR, 32'h09);
      wr(ADDR_CMD, 32'h02);
      rd(ADDR_LDRES, q); `CHK("fuse read", {24'h0, e[i]}, q)
      rd(ADDR_CSR, q); `CHK("csr after fuse read", 32'h0, q)
    end
  endtask

  // Loads and stores landing after their window act normally
  task automatic t_timeout;
    logic [31:0] q;
    wr(ADDR_PTR, 32'h0001);
    wr(ADDR_CSR, 32'h09);
    rd(ADDR_CSR, q);
    wr(ADDR_CMD, 32'h02);
    rd(ADDR_LDRES, q); `CHK("late load", {24'h0, fspc_flash_model_i.mem_r[1]}, q)
    wr(ADDR_CSR, 32'h03);
    rd(ADDR_CSR, q);
    wr(ADDR_CMD, 32'h01);
    rd(ADDR_CSR, q); `CHK("late store csr", 32'h0, q)
    `CHK("late store halt", 1'b0, cpu_halt_out)
  endtask

  task automatic t_ignore;
    logic [31:0] q;
    logic [7:0]  b[6];
    b = '{8'h07, 8'h0B, 8'h19, 8'h02, 8'h08, 8'h1F};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CSR, {24'h0, b[i]});
      rd(ADDR_CSR, q); `CHK("bad pattern", 32'h0, q)
    end
    eeprom_busy_in <= 1'b1;
    wr(ADDR_CSR, 32'h09);
    rd(ADDR_CSR, q); `CHK("eeprom busy", 32'h0, q)
    eeprom_busy_in <= 1'b0;
    // EEPROM activity arriving inside the window still blocks the fuse read
    wr(ADDR_CSR, 32'h09);
    eeprom_busy_in <= 1'b1;
    wr(ADDR_CMD, 32'h02);
    eeprom_busy_in <= 1'b0;
    rd(ADDR_LDRES, q); `CHK("eeprom blocks fuse", {24'h0, fspc_flash_model_i.mem_r[1]}, q)
  endtask

  // Erase, fill with a clear in between, write, then read back
  task automatic t_program;
    logic [31:0] q;
    int          n;
    wr(ADDR_PTR, 32'h0020);
    wr(ADDR_CSR, 32'h03);
    wr(ADDR_CMD, 32'h01);
    wait_op(n); `CHK("erase length", OPC, n)
    `CHK("erased byte", 8'hFF, fspc_flash_model_i.mem_r[8'h21])
    rd(ADDR_CSR, q); `CHK("csr after erase", 32'h0, q)
    store(16'h0024, 16'h5555);
    wr(ADDR_CSR, 32'h11);
    store(16'h0020, 16'h1234);
    store(16'h0023, 16'hABCD);
    wr(ADDR_DATA, 32'h9999);
    wr(ADDR_PTR, 32'h0020);
    wr(ADDR_CSR, 32'h05);
    wr(ADDR_CMD, 32'h01);
    wait_op(n); `CHK("write length", OPC, n)
    `CHK("word 0", 16'h1234, {fspc_flash_model_i.mem_r[8'h21], fspc_flash_model_i.mem_r[8'h20]})
    `CHK("word 1", 16'hABCD, {fspc_flash_model_i.mem_r[8'h23], fspc_flash_model_i.mem_r[8'h22]})
    `CHK("word 2", 16'hFFFF, {fspc_flash_model_i.mem_r[8'h25], fspc_flash_model_i.mem_r[8'h24]})
    wr(ADDR_PTR, 32'h0023);
    wr(ADDR_CMD, 32'h02);
    rd(ADDR_LDRES, q); `CHK("flash load", 32'hAB, q)
  endtask

  // System reset in mid write must not abort the write
  task automatic t_reset_mid;
    int n;
    store(16'h0040, 16'h2468);
    wr(ADDR_PTR, 32'h0040);
    wr(ADDR_CSR, 32'h05);
    wr(ADDR_CMD, 32'h01);
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    `CHK("write in reset", 1'b1, write_o)
    `CHK("halt in reset", 1'b1, cpu_halt_out)
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    wait_op(n);
    `CHK("word after reset", 16'h2468, {fspc_flash_model_i.mem_r[8'h41], fspc_flash_model_i.mem_r[8'h40]})
  endtask

  task automatic final_report;
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    clk_sys_in = 1'b0; rst_n_in = 1'b0; por_n_in = 1'b0;
    avs_address_in = '0; avs_read_in = 1'b0; avs_write_in = 1'b0; avs_writedata_in = '0;
    fuse_lo = 8'h5A; fuse_hi = 8'hC3; lock_b = 8'h03; eeprom_busy_in = 1'b0;
    miscompares = 0; checks = 0;
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    t_regs; t_fuse; t_timeout; t_ignore; t_program; t_reset_mid;
    final_report;
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    final_report;
  end
endmodule
